// ===== dv/mts_sensor_model.sv
// Behavioural SSI multiturn sensor for the turn reader bench
`timescale 1ns/1ps

module mts_sensor_model (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // Link and frame setup
    input  wire logic        i_ssi_clk,
    input  wire logic [4:0]  i_len,
    input  wire logic [31:0] i_word,
    input  wire logic [3:0]  i_bad_frames,
    // Line and statistics
    output logic             o_data,
    output logic [7:0]       o_frames,
    output logic [5:0]       o_bits
);
    logic        clk_q;
    logic [5:0]  cnt;
    logic [6:0]  idle;
    logic [31:0] fw;
    logic [5:0]  pos;

    // Early frames can be spoiled by flipping the trailing error bit
    assign fw  = ({4'h0, o_frames} < {8'h00, i_bad_frames}) ? (i_word ^ 32'h1) : i_word;
    assign pos = 6'(i_len) - 6'h01 - cnt;

    // One bit per falling clock, MSB first; no parity or warning bits appended
    // Idle level is high, so a released line never repeats the last bit
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            clk_q    <= 1'b1;
            cnt      <= 6'h00;
            idle     <= 7'h00;
            o_data   <= 1'b1;
            o_frames <= 8'h00;
            o_bits   <= 6'h00;
        end else begin
            clk_q <= i_ssi_clk;
            if (clk_q && !i_ssi_clk) begin
                o_data <= (cnt < 6'(i_len)) ? fw[pos[4:0]] : 1'b1;
                cnt    <= cnt + 6'h01;
                idle   <= 7'h00;
            end else if (i_ssi_clk && idle < 7'd60) begin
                idle <= idle + 7'h01;
            end else if (idle == 7'd60 && cnt != 6'h00) begin
                o_bits   <= cnt;
                cnt      <= 6'h00;
                o_frames <= o_frames + 8'h01;
                o_data   <= 1'b1;
            end
        end
    end
endmodule // mts_sensor_model

// ===== dv/test_mts_turn_reader.sv
// Self-checking bench for the turn reader
`timescale 1ns/1ps

module test_mts_turn_reader;
    logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        inc = 1'b0, dec = 1'b0, ce = 1'b1;
    logic [9:0]  adr = 10'h000;
    logic [31:0] wdat = 32'h0, word = 32'h0, rdat, odat;
    logic [3:0]  sel = 4'h0, bad = 4'h0, phase = 4'h0;
    logic [4:0]  flen = 5'h0a;
    logic [5:0]  top = 6'h0f, nbits, stx;
    logic [15:0] stpos = 16'h1234;
    logic        ack, sclk, sdata, vld, done;
    logic [39:0] pos;
    logic [7:0]  frames;
    int          errors = 0, num_checks = 0, f;
    // Every mode below assumes main_track_periods under 0x07
    logic [3:0]  tm[7] = '{4'hb, 4'hc, 4'hd, 4'he, 4'hf, 4'h3, 4'h8};
    logic [1:0]  ts[7] = '{2'h2, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1};
    logic [1:0]  te[7] = '{2'h2, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h3};
    logic [4:0]  tl[7] = '{5'd7, 5'd9, 5'd14, 5'd19, 5'd23, 5'd4, 5'd19};
    logic [31:0] tw[7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'ha, 32'h48};
    logic [5:0]  tst[7] = '{6'h0, 6'h0, 6'h0, 6'h0, 6'h0, 6'h05, 6'h09};
    logic [9:0]  ra[5] = '{10'h038, 10'h03c, 10'h040, 10'h04c, 10'h3fc};

    always #5 clk = ~clk;

    mts_turn_reader #(.CHECK_CYCLES(300), .GAP_CYCLES(20)) i_mts_turn_reader (
        .i_clk(clk), .i_rst(rst), .i_ce(ce), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(odat), .o_wb_ack(ack),
        .o_ssi_clk(sclk), .i_ssi_data(sdata), .i_st_inc(inc), .i_st_dec(dec),
        .i_st_phase(phase), .i_st_pos(stpos), .i_out_top_bit(top), .o_pos_word(pos),
        .o_st_ext_bits(stx), .o_st_ext_valid(vld), .o_start_done(done));

    mts_sensor_model i_mts_sensor_model (
        .i_clk(clk), .i_rst(rst), .i_ssi_clk(sclk), .i_len(flen), .i_word(word),
        .i_bad_frames(bad), .o_data(sdata), .o_frames(frames), .o_bits(nbits));

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // Classic cycle; ack and data are read at the rising edge, before that edge updates them
    task automatic wb(input logic [9:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk(40'h0, 40'h1, "bus timeout");
            tally_and_finish;
        end
        rdat = odat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] a, input logic [39:0] e, input string m);
        wb(a, 1'b0, 32'h0);
        chk(40'(rdat), e, m);
    endtask

    task automatic stat_err(input logic e);
        wb(10'h048, 1'b0, 32'h0);
        chk(40'(rdat[1]), 40'(e), "verify error flag");
    endtask

    task automatic wait_frames(input int n);
        int k;
        k = 0;
        while (int'(frames) < n && k < 20000) begin
            @(negedge clk);
            k++;
        end
        if (k >= 20000) begin
            chk(40'h0, 40'h1, "frame wait timeout");
            tally_and_finish;
        end
        repeat (5) @(negedge clk);
    endtask

    task automatic verify;
        f = int'(frames);
        wb(10'h044, 1'b1, 32'h1);
        wait_frames(f + 1);
    endtask

    task automatic pulse(input logic up, input int n);
        repeat (n) begin
            @(posedge clk);
            inc <= up; dec <= !up;
            @(posedge clk);
            inc <= 1'b0; dec <= 1'b0;
        end
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        foreach (ra[i]) rd(ra[i], 40'h0, "reset or unmapped value");
        rd(10'h048, 40'h1, "start done in mode zero");
        $display("test reset done");
        // First frame is spoiled, so startup must read a second time
        flen <= 5'd10; word <= 32'h169; bad <= 4'h1;
        wb(10'h038, 1'b1, 32'h40);
        wb(10'h03c, 1'b1, 32'h30);
        wb(10'h040, 1'b1, 32'h0c);
        wait_frames(1);
        chk(40'(done), 40'h0, "startup held after read error");
        rd(10'h048, 40'h4, "read error flagged");
        wait_frames(2);
        chk(40'(frames), 40'h2, "startup retry count");
        chk(40'(done), 40'h1, "startup done after good read");
        rd(10'h04c, 40'h5d, "startup load with offset");
        @(posedge clk) top <= 6'd39;
        repeat (3) @(negedge clk);
        chk(pos, {24'h5d, 16'h1234}, "position with turn bits");
        @(posedge clk) top <= 6'd15;
        repeat (3) @(negedge clk);
        chk(pos, {24'h0, 16'h1234}, "position without turn bits");
        pulse(1'b1, 2);
        pulse(1'b0, 1);
        rd(10'h04c, 40'h5e, "internal counting");
        $display("test startup done");
        word <= 32'h16d;
        verify;
        stat_err(1'b0);
        // Sync bit one only matches when the internal phase half is taken into account
        phase <= 4'h8; word <= 32'h16f;
        verify;
        stat_err(1'b0);
        phase <= 4'h0;
        word <= 32'h081;
        verify;
        stat_err(1'b1);
        wb(10'h048, 1'b1, 32'h2);
        stat_err(1'b0);
        wb(10'h03c, 1'b1, 32'h0);
        wb(10'h038, 1'b1, 32'h60);
        word <= 32'h287;
        verify;
        stat_err(1'b0);
        $display("test verify done");
        wb(10'h038, 1'b1, 32'h40);
        word <= 32'h047;
        f = int'(frames);
        repeat (1500) @(negedge clk);
        chk(40'(frames), 40'(f), "no read with check off");
        stat_err(1'b0);
        wb(10'h040, 1'b1, 32'h4c);
        wait_frames(f + 1);
        stat_err(1'b1);
        wb(10'h040, 1'b1, 32'h0c);
        // A check already due still runs one more frame before the link falls quiet
        repeat (2500) @(negedge clk);
        $display("test periodic check done");
        foreach (tm[i]) begin
            wb(10'h038, 1'b1, {24'h0, te[i], 6'h00});
            wb(10'h040, 1'b1, {24'h0, 2'b00, ts[i], tm[i]});
            flen <= tl[i]; word <= tw[i];
            verify;
            chk(40'(nbits), 40'(tl[i]), "frame length");
            chk(40'(vld), 40'(tm[i] < 4'hb), "singleturn valid");
            if (tm[i] < 4'hb) chk(40'(stx), 40'(tst[i]), "singleturn bits");
        end
        $display("test frame formats done");
        wb(10'h040, 1'b1, 32'h0);
        f = int'(frames);
        wb(10'h044, 1'b1, 32'h1);
        repeat (300) @(negedge clk);
        chk(40'(frames), 40'(f), "no link use in mode zero");
        chk(40'(sclk), 40'h1, "link clock idle");
        pulse(1'b0, 95);
        rd(10'h04c, 40'hffffff, "counter wraps down");
        pulse(1'b1, 1);
        rd(10'h04c, 40'h0, "counter wraps up");
        @(posedge clk) ce <= 1'b0;
        pulse(1'b1, 3);
        @(posedge clk) ce <= 1'b1;
        rd(10'h04c, 40'h0, "clock enable freezes counter");
        $display("test mode zero done");
        tally_and_finish;
    end
endmodule // test_mts_turn_reader

// ===== include/mts_defines.svh
// Register indices, field positions, reset values and timing counts for the turn reader
`ifndef MTS_DEFINES_SVH
`define MTS_DEFINES_SVH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define MTS_IDX_DIR      8'h0e
`define MTS_IDX_OFS      8'h0f
`define MTS_IDX_MODE     8'h10
`define MTS_IDX_CMD      8'h11
`define MTS_IDX_STAT     8'h12
`define MTS_IDX_TURN     8'h13

// ****************************************
// Field positions
// ****************************************
`define MTS_DIR_INV_BIT  5
`define MTS_ERR_CFG_LSB  6
`define MTS_OFS_LSB      4
`define MTS_MODE_LSB     0
`define MTS_SYNC_LSB     4
`define MTS_CHECK_BIT    6
`define MTS_CMD_VER_BIT  0
`define MTS_STAT_DONE    0
`define MTS_STAT_VERR    1
`define MTS_STAT_FAIL    2

// ****************************************
// Reset values
// ****************************************
`define MTS_RST_REG8     8'h00
`define MTS_RST_TURN     24'h000000

// ****************************************
// Timing
// ****************************************
`define MTS_CLK_NS       10
`define MTS_HALF_NS      500
`define MTS_GAP_NS       20000
`define MTS_CHECK_NS     1000000
`define MTS_HALF_CYC     ((`MTS_HALF_NS + `MTS_CLK_NS - 1) / `MTS_CLK_NS)
`define MTS_GAP_CYC      ((`MTS_GAP_NS + `MTS_CLK_NS - 1) / `MTS_CLK_NS)
`define MTS_CHECK_CYC    (`MTS_CHECK_NS / `MTS_CLK_NS)

`endif

// ===== include/mts_pkg.sv
// Types shared by the turn reader
package mts_pkg;
    typedef enum logic [2:0] {
        MTS_IDLE,
        MTS_LOW,
        MTS_HIGH,
        MTS_EVAL,
        MTS_GAP
    } mts_state_t;
endpackage

// ===== rtl/mts_turn_reader.sv
// External SSI multiturn reader with internal turn counter and verification
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
`include "mts_defines.svh"

module mts_turn_reader #(
    parameter int CHECK_CYCLES = `MTS_CHECK_CYC,
    parameter int GAP_CYCLES   = `MTS_GAP_CYC
) (
    // Clock, reset, enable
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    // Wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [9:0]  i_wb_adr,
    input  wire logic [31:0] i_wb_dat,
    input  wire logic [3:0]  i_wb_sel,
    output logic [31:0]      o_wb_dat,
    output logic             o_wb_ack,
    // SSI link
    output logic             o_ssi_clk,
    input  wire logic        i_ssi_data,
    // Singleturn side
    input  wire logic        i_st_inc,
    input  wire logic        i_st_dec,
    input  wire logic [3:0]  i_st_phase,
    input  wire logic [15:0] i_st_pos,
    input  wire logic [5:0]  i_out_top_bit,
    output logic [39:0]      o_pos_word,
    output logic [5:0]       o_st_ext_bits,
    output logic             o_st_ext_valid,
    output logic             o_start_done
);
    localparam int HC = `MTS_HALF_CYC;

    // ****************************************
    // Decode functions
    // ****************************************
    function automatic logic [4:0] data_bits(input logic [3:0] m);
        case (m)
            4'h0:    data_bits = 5'h00;
            4'h7:    data_bits = 5'h0f;
            4'h8:    data_bits = 5'h10;
            4'h9:    data_bits = 5'h11;
            4'ha:    data_bits = 5'h12;
            4'hb:    data_bits = 5'h04;
            4'hc:    data_bits = 5'h08;
            4'hd:    data_bits = 5'h0c;
            4'he:    data_bits = 5'h10;
            4'hf:    data_bits = 5'h12;
            default: data_bits = {1'b0, m};
        endcase
    endfunction

    function automatic logic [4:0] st_bits(input logic [3:0] m);
        if (m >= 4'h1 && m <= 4'h6) begin
            st_bits = {1'b0, m};
        end else if (m >= 4'h7 && m <= 4'ha) begin
            st_bits = {1'b0, m} - 5'h04;
        end else begin
            st_bits = 5'h00;
        end
    endfunction

    function automatic logic [31:0] mask(input logic [4:0] n);
        mask = (32'h1 << n) - 32'h1;
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0]  dir_reg, ofs_reg, mode_reg;
    logic        verr_reg, fail_reg, done_reg, pend_reg;
    logic [23:0] turn_reg;
    mts_pkg::mts_state_t state_reg;
    logic [15:0] tick_reg;
    logic [4:0]  bit_reg;
    logic [31:0] shift_reg;
    logic [31:0] chk_reg;
    logic        sd_meta_reg, sd_reg;

    wire [3:0] mode    = mode_reg[`MTS_MODE_LSB +: 4];
    wire [1:0] sync_c  = mode_reg[`MTS_SYNC_LSB +: 2];
    wire       chk_en  = mode_reg[`MTS_CHECK_BIT];
    wire [1:0] err_c   = dir_reg[`MTS_ERR_CFG_LSB +: 2];
    wire       inv     = dir_reg[`MTS_DIR_INV_BIT];
    wire [3:0] ofs     = ofs_reg[`MTS_OFS_LSB +: 4];

    wire [4:0] n_sync  = {3'h0, sync_c} + 5'h01;
    wire [4:0] n_err   = (err_c == 2'h1 || err_c == 2'h3) ? 5'h01 : 5'h00;
    wire [4:0] n_dat   = data_bits(mode);
    wire [4:0] n_st    = st_bits(mode);
    wire [4:0] n_mt    = n_dat - n_st;
    wire [4:0] frm_len = n_dat + n_sync + n_err;

    // ****************************************
    // Wishbone slave
    // ****************************************
    wire [7:0] idx  = i_wb_adr[9:2];
    wire       req  = i_wb_cyc && i_wb_stb && !o_wb_ack;
    wire       wr0  = req && i_wb_we && i_wb_sel[0];
    wire       vcmd = wr0 && idx == `MTS_IDX_CMD && i_wb_dat[`MTS_CMD_VER_BIT];
    wire       vclr = wr0 && idx == `MTS_IDX_STAT && i_wb_dat[`MTS_STAT_VERR];

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0;
        end else if (i_ce) begin
            o_wb_ack <= req;
            if (req) begin
                case (idx)
                    `MTS_IDX_DIR:  o_wb_dat <= {24'h0, dir_reg};
                    `MTS_IDX_OFS:  o_wb_dat <= {24'h0, ofs_reg};
                    `MTS_IDX_MODE: o_wb_dat <= {24'h0, mode_reg};
                    `MTS_IDX_STAT: o_wb_dat <= {29'h0, fail_reg, verr_reg, done_reg};
                    `MTS_IDX_TURN: o_wb_dat <= {8'h0, turn_reg};
                    default:       o_wb_dat <= 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            dir_reg  <= `MTS_RST_REG8;
            ofs_reg  <= `MTS_RST_REG8;
            mode_reg <= `MTS_RST_REG8;
        end else if (i_ce && wr0) begin
            if (idx == `MTS_IDX_DIR) begin
                dir_reg <= i_wb_dat[7:0] & 8'he0;
            end
            if (idx == `MTS_IDX_OFS) begin
                ofs_reg <= i_wb_dat[7:0] & 8'hf0;
            end
            if (idx == `MTS_IDX_MODE) begin
                mode_reg <= i_wb_dat[7:0] & 8'h7f;
            end
        end
    end

    // ****************************************
    // Data line synchroniser
    // ****************************************
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sd_meta_reg <= 1'b0;
            sd_reg      <= 1'b0;
        end else if (i_ce) begin
            sd_meta_reg <= i_ssi_data;
            sd_reg      <= sd_meta_reg;
        end
    end

    // ****************************************
    // Frame evaluation
    // ****************************************
    logic [31:0] raw, sv, dat, mt, comb, diff, adj, r, nt;
    logic        half, err_hit, ok;
    logic [23:0] sync_turn;
    logic [5:0]  st_val;

    always_comb begin
        raw  = shift_reg >> n_err;
        sv   = raw & mask(n_sync);
        dat  = (raw >> n_sync) & mask(n_dat);
        if (inv) begin
            dat = ~dat & mask(n_dat);
            sv  = ~sv & mask(n_sync);
        end
        st_val = 6'(dat & mask(n_st));
        mt   = ((dat >> n_st) + {28'h0, ofs}) & mask(n_mt);
        comb = (mt << n_sync) | sv;
        diff = comb - ({28'h0, i_st_phase} >> (5'h04 - n_sync));
        r    = diff & mask(n_sync);
        half = r >= (32'h1 << (n_sync - 5'h01));
        nt   = half ? (32'h1 << n_sync) - r : r;
        adj  = half ? diff + nt : diff - r;
        sync_turn = 24'((adj >> n_sync) & mask(n_mt));
        // Tolerance in sync-bit units: 0, 1, 3, 7
        ok = 1'b1;
        if (nt > (32'h1 << sync_c) - 32'h1) begin
            ok = 1'b0;
        end
        err_hit = (err_c == 2'h1 && !shift_reg[0])
               || (err_c == 2'h3 && shift_reg[0]);
        if (err_hit) begin
            ok = 1'b0;
        end
    end

    wire eval     = state_reg == mts_pkg::MTS_EVAL;
    wire mismatch = !ok || ((turn_reg & 24'(mask(n_mt))) != sync_turn);
    wire start_rd = state_reg == mts_pkg::MTS_IDLE && mode != 4'h0
                    && (!done_reg || pend_reg);

    // ****************************************
    // SSI clock master
    // ****************************************
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= mts_pkg::MTS_IDLE;
            tick_reg  <= 16'h0;
            bit_reg   <= 5'h0;
            shift_reg <= 32'h0;
            o_ssi_clk <= 1'b1;
        end else if (i_ce) begin
            case (state_reg)
                mts_pkg::MTS_IDLE: begin
                    if (start_rd) begin
                        state_reg <= mts_pkg::MTS_LOW;
                        o_ssi_clk <= 1'b0;
                        tick_reg  <= 16'h0;
                        bit_reg   <= 5'h0;
                        shift_reg <= 32'h0;
                    end
                end
                mts_pkg::MTS_LOW: begin
                    tick_reg <= tick_reg + 16'h1;
                    if (tick_reg == 16'(HC - 1)) begin
                        state_reg <= mts_pkg::MTS_HIGH;
                        o_ssi_clk <= 1'b1;
                        tick_reg  <= 16'h0;
                    end
                end
                mts_pkg::MTS_HIGH: begin
                    tick_reg <= tick_reg + 16'h1;
                    if (tick_reg == 16'(HC - 1)) begin
                        // Late sample leaves room for the synchroniser delay
                        shift_reg <= {shift_reg[30:0], sd_reg};
                        bit_reg   <= bit_reg + 5'h1;
                        tick_reg  <= 16'h0;
                        if (bit_reg + 5'h1 == frm_len) begin
                            state_reg <= mts_pkg::MTS_EVAL;
                        end else begin
                            state_reg <= mts_pkg::MTS_LOW;
                            o_ssi_clk <= 1'b0;
                        end
                    end
                end
                mts_pkg::MTS_EVAL: begin
                    state_reg <= mts_pkg::MTS_GAP;
                end
                mts_pkg::MTS_GAP: begin
                    // Clock held high so the sensor's monoflop can expire
                    tick_reg <= tick_reg + 16'h1;
                    if (tick_reg == 16'(GAP_CYCLES - 1)) begin
                        state_reg <= mts_pkg::MTS_IDLE;
                    end
                end
                default: begin
                    state_reg <= mts_pkg::MTS_IDLE;
                    o_ssi_clk <= 1'b1;
                end
            endcase
        end
    end

    // ****************************************
    // Turn counter and startup
    // ****************************************
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            turn_reg <= `MTS_RST_TURN;
            done_reg <= 1'b0;
            fail_reg <= 1'b0;
        end else if (i_ce) begin
            if (wr0 && idx == `MTS_IDX_MODE && mode == 4'h0 && |i_wb_dat[`MTS_MODE_LSB +: 4]) begin
                done_reg <= 1'b0;                     // Leaving mode zero restarts read-in
            end else if (!done_reg && mode == 4'h0) begin
                done_reg <= 1'b1;
            end else if (eval && !done_reg) begin
                fail_reg <= !ok;
                if (ok) begin
                    turn_reg <= sync_turn;
                    done_reg <= 1'b1;
                end
            end else if (done_reg && i_st_inc != i_st_dec) begin
                turn_reg <= i_st_inc ? turn_reg + 24'h1 : turn_reg - 24'h1;
            end
            if (eval && done_reg) begin
                fail_reg <= !ok;
            end
        end
    end

    // ****************************************
    // Verification
    // ****************************************
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            chk_reg  <= 32'h0;
            pend_reg <= 1'b0;
            verr_reg <= 1'b0;
        end else if (i_ce) begin
            if (chk_en && done_reg && mode != 4'h0) begin
                chk_reg <= (chk_reg == 32'(CHECK_CYCLES - 1)) ? 32'h0 : chk_reg + 32'h1;
            end else begin
                chk_reg <= 32'h0;
            end
            if (start_rd && done_reg) begin
                pend_reg <= 1'b0;
            end
            if (vcmd || (chk_en && chk_reg == 32'(CHECK_CYCLES - 1))) begin
                pend_reg <= 1'b1;
            end
            if (vclr) begin
                verr_reg <= 1'b0;
            end
            if (eval && done_reg && mismatch) begin
                verr_reg <= 1'b1;
            end
        end
    end

    // ****************************************
    // Position outputs
    // ****************************************
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pos_word     <= 40'h0;
            o_st_ext_bits  <= 6'h0;
            o_st_ext_valid <= 1'b0;
        end else if (i_ce) begin
            o_pos_word <= {turn_reg, i_st_pos}
                          & ((40'h2 << i_out_top_bit) - 40'h1);
            if (eval && ok) begin
                o_st_ext_bits  <= st_val;
                o_st_ext_valid <= n_st != 5'h0;
            end
        end
    end

    assign o_start_done = done_reg;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_low_half;
        !o_ssi_clk ##(HC - 1) !o_ssi_clk ##1 o_ssi_clk;
    endsequence

    ack_single_a: assert property (i_ce && o_wb_ack |=> !o_wb_ack)
        else $error("ack held two cycles");
    ssi_low_a: assert property ($fell(o_ssi_clk) |-> s_low_half)
        else $error("ssi low phase wrong");
    frame_len_a: assert property (i_ce && $rose(eval) |-> bit_reg == frm_len)
        else $error("frame length mismatch");
    start_load_a: assert property (i_ce && eval && !done_reg && ok
        |=> done_reg && turn_reg == $past(sync_turn))
        else $error("start value not loaded");
    start_retry_a: assert property (i_ce && eval && !done_reg && !ok
        |=> !done_reg ##1 state_reg == mts_pkg::MTS_GAP)
        else $error("failed start not retried");
    turn_inc_a: assert property (i_ce && done_reg && !eval && i_st_inc
        && !i_st_dec |=> turn_reg == $past(turn_reg) + 24'h1)
        else $error("turn count not advanced");
    no_read_a: assert property (mode == 4'h0 && state_reg == mts_pkg::MTS_IDLE
        |=> o_ssi_clk)
        else $error("read started in mode zero");
    verify_err_a: assert property (i_ce && eval && done_reg && mismatch
        |=> verr_reg)
        else $error("mismatch not flagged");
    top_mask_a: assert property (i_ce && i_out_top_bit < 6'h27
        |=> o_pos_word >> ($past(i_out_top_bit) + 6'h1) == 40'h0)
        else $error("bits above top bit set");
    st_out_a: assert property (i_ce && eval && ok |=> o_st_ext_bits == $past(st_val))
        else $error("singleturn bits not output");

endmodule // mts_turn_reader
